/* common/txdyn_map.svh */
/*
 * Property numbers, field widths, reset values and timing counts of the
 * transmit dynamics and signal-quality settings.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef TXDYN_MAP_SVH
`define TXDYN_MAP_SVH

// property numbers as seen on the command port
`define TXDYN_PROP_COMP_THRESHOLD  16'h2201
`define TXDYN_PROP_COMP_RELEASE    16'h2203
`define TXDYN_PROP_COMP_GAIN       16'h2204
`define TXDYN_PROP_LIM_RELEASE     16'h2205
`define TXDYN_PROP_QUALITY_SELECT  16'h2300
`define TXDYN_PROP_QUIET_THRESHOLD 16'h2301
`define TXDYN_PROP_QUIET_DURATION  16'h2302

// reset values
`define TXDYN_RST_COMP_THRESHOLD   16'hFFD8
`define TXDYN_RST_COMP_RELEASE     3'h4
`define TXDYN_RST_COMP_GAIN        6'h0F
`define TXDYN_RST_LIM_RELEASE      16'h0066
`define TXDYN_RST_QUALITY_SELECT   3'h0
`define TXDYN_RST_QUIET_THRESHOLD  8'h00
`define TXDYN_RST_QUIET_DURATION   16'h0000

// field limits
`define TXDYN_COMP_RELEASE_MAX     3'h4
`define TXDYN_COMP_GAIN_MAX        6'h14
`define TXDYN_LIM_RELEASE_MIN      16'h0005
`define TXDYN_LIM_RELEASE_MAX      16'h07D0
`define TXDYN_QUIET_THRESHOLD_MIN  (-70)
`define TXDYN_COMP_THRESHOLD_MIN   (-40)

// detector select bit positions
`define TXDYN_SEL_QUIET_BIT        0
`define TXDYN_SEL_LOUD_BIT         1
`define TXDYN_SEL_OVERDEV_BIT      2

// compressor release times in ms
`define TXDYN_REL0_MS              10'd100
`define TXDYN_REL1_MS              10'd200
`define TXDYN_REL2_MS              10'd350
`define TXDYN_REL3_MS              10'd525
`define TXDYN_REL4_MS              10'd1000

// timing: clock rate and the 1 ms duration unit
`define TXDYN_CLK_HZ               25000000
`define TXDYN_UNIT_MS              1
`define TXDYN_MS_CYCLES            ((`TXDYN_CLK_HZ / 1000) * `TXDYN_UNIT_MS)

`endif

/* common/txdyn_pkg.sv */
/*
 * Types shared by the transmit dynamics block.
 * Assumes txdyn_map.svh is on the include path.
 */
package txdyn_pkg;
`include "txdyn_map.svh"

    // one property access from the host
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] prop;
        logic [15:0] data;
    } txdyn_cmd_t;

    // signal-quality status answer
    typedef struct packed {
        logic valid;
        logic overdeviation_flag;
        logic loud_input_flag;
        logic quiet_input_flag;
    } txdyn_status_t;

    // every flip-flop of the top module
    typedef struct packed {
        logic [15:0]   comp_thr;
        logic [2:0]    comp_rel;
        logic [5:0]    comp_gain;
        logic [15:0]   limiter_release_count;
        logic [2:0]    det_sel;
        logic [7:0]    quiet_input_threshold;
        logic [15:0]   quiet_input_duration;
        logic          cts;
        logic          rvalid;
        logic [15:0]   rdata;
        logic          err;
        logic          tuned;
        logic [2:0]    flags;
        logic          stat_valid;
        txdyn_status_t stat;
        logic          above_comp;
        logic [9:0]    rel_left;
        logic          rel_active;
        logic [5:0]    gain_out;
        logic          above_lim;
        logic          lim_start;
    } txdyn_state_t;

    // compressor release code to milliseconds
    function automatic logic [9:0] txdyn_release_ms(input logic [2:0] code);
        case (code)
            3'h0:    return `TXDYN_REL0_MS;
            3'h1:    return `TXDYN_REL1_MS;
            3'h2:    return `TXDYN_REL2_MS;
            3'h3:    return `TXDYN_REL3_MS;
            default: return `TXDYN_REL4_MS;
        endcase
    endfunction
endpackage

/* src/txdyn_ms_tick.sv */
/*
 * Millisecond tick generator for the dynamics block.
 * Assumes one clock; i_srst synchronous active high.
 */
`timescale 1ns/1ns
module txdyn_ms_tick #(
    parameter int unsigned CYCLES = 25000
) (
    input  wire logic i_clk,
    input  wire logic i_srst,
    output logic      o_tick
);
    import txdyn_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } txdyn_tick_state_t;

    txdyn_tick_state_t s_reg;
    txdyn_tick_state_t s_next;

    if (CYCLES < 1) begin : g_chk
        $error("txdyn_ms_tick: CYCLES must be at least 1");
    end

    // free-running divider, one pulse per CYCLES clocks
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.cnt == 32'(CYCLES - 1)) begin
            s_next.cnt = 32'h0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + 32'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_tick = s_reg.tick;
endmodule

/* src/txdyn_quiet_det.sv */
/*
 * Quiet-input duration detector: fires once the level has stayed below
 * the threshold for the programmed number of milliseconds.
 * Assumes i_tick is one-cycle pulse each ms from the same clock.
 */
`timescale 1ns/1ns
module txdyn_quiet_det (
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        i_run,
    input  wire logic        i_below,
    input  wire logic        i_tick,
    input  wire logic [15:0] i_duration,
    output logic             o_hit
);
    import txdyn_pkg::*;

    typedef struct packed {
        logic [15:0] ms;
        logic        fired;
        logic        hit;
    } txdyn_quiet_state_t;

    txdyn_quiet_state_t s_reg;
    txdyn_quiet_state_t s_next;

    // any break in the quiet run restarts the count
    always_comb begin
        s_next = s_reg;
        s_next.hit = 1'b0;
        if (!i_run || !i_below) begin
            s_next = '0;
        end else if (!s_reg.fired && s_reg.ms >= i_duration) begin
            s_next.hit = 1'b1;
            s_next.fired = 1'b1;
        end else if (i_tick && s_reg.ms != 16'hFFFF) begin
            s_next.ms = s_reg.ms + 16'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_hit = s_reg.hit;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    property p_quiet_needs_time;
        o_hit |-> $past(s_reg.ms >= i_duration) && $past(i_below) && $past(i_run);
    endproperty
    a_quiet_needs_time: assert property (p_quiet_needs_time)
        else $error("quiet hit before duration elapsed");
endmodule

/* src/txdyn_top.sv */
/*
 * Transmit audio dynamics and signal-quality settings: property
 * store behind the command port, compressor gain and release timing,
 * limiter release start, and the quality detectors with their status.
 * Assumes the command port, level inputs and events come from logic on
 * i_clk; an access taken while i_powered_up is low is refused with err.
 */
`timescale 1ns/1ns
`include "txdyn_map.svh"
// Behaviour
// - release code 0..4 maps 100..1000 ms, resets 4
// - release time starts on compression-to-gain fall
// - gain is 6 bits, 0..20 dB, resets 15
// - gain applies only below compression threshold
// - clear-to-send returns after each access
// - limiter release 16 bits, 5..2000, resets 102
// - limiter release used on falling below threshold
// - overdeviation reported only when select bit 2
// - bit 1 loud, bit 0 quiet; all off
// - status returns only enabled detector flags
// - quiet threshold 8-bit dBFS, -70..0, resets 0
// - quiet candidate only while below threshold
// - quiet duration 16-bit ms count, resets 0
// - quiet flag after full continuous duration
// - detectors and status run after tune command; the code also answers status before tune, with valid low
// - compression threshold signed dB, resets -40
module txdyn_top #(
    parameter int unsigned MS_CYCLES = `TXDYN_MS_CYCLES
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_srst,
    input  wire logic                    i_powered_up,
    input  wire txdyn_pkg::txdyn_cmd_t   i_cmd,
    input  wire logic                    i_tune_cmd,
    input  wire logic                    i_status_req,
    input  wire logic [7:0]              i_level_dbfs,
    input  wire logic                    i_over_limit,
    input  wire logic                    i_overdev_event,
    input  wire logic                    i_loud_event,
    output logic                         o_cts,
    output logic                         o_rvalid,
    output logic [15:0]                  o_rdata,
    output logic                         o_err,
    output logic                         o_stat_valid,
    output txdyn_pkg::txdyn_status_t     o_stat,
    output logic [5:0]                   o_gain_db,
    output logic                         o_comp_releasing,
    output logic                         o_lim_release_start,
    output logic [15:0]                  o_limiter_release_count
);
    import txdyn_pkg::*;

    txdyn_state_t s_reg;
    txdyn_state_t s_next;
    logic         ms_tick;
    logic         quiet_hit;
    logic         quiet_below;
    logic         comp_above;
    logic         cmd_take;
    logic [15:0]  rd_word;
    logic         rd_hit;
    logic [2:0]   events;

    if (MS_CYCLES < 1) begin : g_chk
        $error("txdyn_top: MS_CYCLES must be at least 1");
    end

    txdyn_ms_tick #(
        .CYCLES (MS_CYCLES)
    ) u_tick (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .o_tick (ms_tick)
    );

    // candidate only while strictly below the quiet threshold
    assign quiet_below = $signed(i_level_dbfs) < $signed(s_reg.quiet_input_threshold);

    txdyn_quiet_det u_quiet (
        .i_clk      (i_clk),
        .i_srst     (i_srst),
        .i_run      (s_reg.tuned && s_reg.det_sel[`TXDYN_SEL_QUIET_BIT]),
        .i_below    (quiet_below),
        .i_tick     (ms_tick),
        .i_duration (s_reg.quiet_input_duration),
        .o_hit      (quiet_hit)
    );

    // threshold is a small signed dB value, low byte carries it
    assign comp_above = $signed(i_level_dbfs) >= $signed(s_reg.comp_thr[7:0]);
    assign cmd_take = i_cmd.valid && s_reg.cts;

    // read mux; fields sit in low bits, everything above reads zero
    always_comb begin
        rd_word = 16'h0000;
        rd_hit = 1'b1;
        case (i_cmd.prop)
            `TXDYN_PROP_COMP_THRESHOLD:  rd_word = s_reg.comp_thr;
            `TXDYN_PROP_COMP_RELEASE:    rd_word = {13'h0000, s_reg.comp_rel};
            `TXDYN_PROP_COMP_GAIN:       rd_word = {10'h000, s_reg.comp_gain};
            `TXDYN_PROP_LIM_RELEASE:     rd_word = s_reg.limiter_release_count;
            `TXDYN_PROP_QUALITY_SELECT:  rd_word = {13'h0000, s_reg.det_sel};
            `TXDYN_PROP_QUIET_THRESHOLD: rd_word = {8'h00, s_reg.quiet_input_threshold};
            `TXDYN_PROP_QUIET_DURATION:  rd_word = s_reg.quiet_input_duration;
            default:                     rd_hit = 1'b0;
        endcase
    end

    // detector events, each gated by its enable and by a prior tune
    always_comb begin
        events = 3'h0;
        if (s_reg.tuned) begin
            events[`TXDYN_SEL_OVERDEV_BIT] = i_overdev_event &&
                s_reg.det_sel[`TXDYN_SEL_OVERDEV_BIT];
            events[`TXDYN_SEL_LOUD_BIT] = i_loud_event &&
                s_reg.det_sel[`TXDYN_SEL_LOUD_BIT];
            events[`TXDYN_SEL_QUIET_BIT] = quiet_hit;
        end
    end

    // next-state: property access, status, compressor and limiter
    always_comb begin
        s_next = s_reg;
        s_next.cts = 1'b1;
        s_next.rvalid = 1'b0;
        s_next.err = 1'b0;
        s_next.stat_valid = 1'b0;
        s_next.lim_start = 1'b0;

        // a busy cycle follows every taken access, then cts returns
        if (cmd_take) begin
            s_next.cts = 1'b0;
            if (!i_powered_up) begin
                s_next.err = 1'b1;
            end else if (!i_cmd.write) begin
                s_next.rvalid = 1'b1;
                s_next.rdata = rd_word;
                s_next.err = !rd_hit;
            end else begin
                // out-of-range writes keep the old value and flag err
                case (i_cmd.prop)
                    `TXDYN_PROP_COMP_THRESHOLD: begin
                        if ($signed(i_cmd.data) <= 0 &&
                            $signed(i_cmd.data) >= `TXDYN_COMP_THRESHOLD_MIN) begin
                            s_next.comp_thr = i_cmd.data;
                        end else begin
                            s_next.err = 1'b1;
                        end
                    end
                    `TXDYN_PROP_COMP_RELEASE: begin
                        if (i_cmd.data <= 16'(`TXDYN_COMP_RELEASE_MAX)) begin
                            s_next.comp_rel = i_cmd.data[2:0];
                        end else begin
                            s_next.err = 1'b1;
                        end
                    end
                    `TXDYN_PROP_COMP_GAIN: begin
                        if (i_cmd.data <= 16'(`TXDYN_COMP_GAIN_MAX)) begin
                            s_next.comp_gain = i_cmd.data[5:0];
                        end else begin
                            s_next.err = 1'b1;
                        end
                    end
                    `TXDYN_PROP_LIM_RELEASE: begin
                        if (i_cmd.data >= `TXDYN_LIM_RELEASE_MIN &&
                            i_cmd.data <= `TXDYN_LIM_RELEASE_MAX) begin
                            s_next.limiter_release_count = i_cmd.data;
                        end else begin
                            s_next.err = 1'b1;
                        end
                    end
                    `TXDYN_PROP_QUALITY_SELECT: begin
                        s_next.det_sel = i_cmd.data[2:0];
                    end
                    `TXDYN_PROP_QUIET_THRESHOLD: begin
                        if (i_cmd.data[15:8] == 8'h00 &&
                            $signed(i_cmd.data[7:0]) <= 0 &&
                            $signed(i_cmd.data[7:0]) >= `TXDYN_QUIET_THRESHOLD_MIN) begin
                            s_next.quiet_input_threshold = i_cmd.data[7:0];
                        end else begin
                            s_next.err = 1'b1;
                        end
                    end
                    `TXDYN_PROP_QUIET_DURATION: begin
                        s_next.quiet_input_duration = i_cmd.data;
                    end
                    default: begin
                        s_next.err = 1'b1;
                    end
                endcase
            end
        end

        // tune arms the detectors; stays armed until reset
        if (i_tune_cmd) begin
            s_next.tuned = 1'b1;
        end

        // status read clears the flags, but a same-cycle event survives
        s_next.flags = s_reg.flags | events;
        if (i_status_req && s_reg.cts && !i_cmd.valid) begin
            s_next.stat_valid = 1'b1;
            s_next.stat.valid = s_reg.tuned;
            s_next.stat.overdeviation_flag = s_reg.flags[2] && s_reg.det_sel[2];
            s_next.stat.loud_input_flag = s_reg.flags[1] && s_reg.det_sel[1];
            s_next.stat.quiet_input_flag = s_reg.flags[0] && s_reg.det_sel[0];
            s_next.flags = events;
        end

        // compressor: full gain below threshold, none in compression
        s_next.above_comp = comp_above;
        s_next.gain_out = comp_above ? 6'h00 : s_reg.comp_gain;
        if (s_reg.above_comp && !comp_above) begin
            s_next.rel_left = txdyn_release_ms(s_reg.comp_rel);
        end else if (ms_tick && s_reg.rel_left != 10'h000) begin
            s_next.rel_left = s_reg.rel_left - 10'h001;
        end
        s_next.rel_active = s_next.rel_left != 10'h000;

        // limiter: release starts when level drops back under limit
        s_next.above_lim = i_over_limit;
        s_next.lim_start = s_reg.above_lim && !i_over_limit;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_reg <= '0;
            s_reg.comp_thr <= `TXDYN_RST_COMP_THRESHOLD;
            s_reg.comp_rel <= `TXDYN_RST_COMP_RELEASE;
            s_reg.comp_gain <= `TXDYN_RST_COMP_GAIN;
            s_reg.limiter_release_count <= `TXDYN_RST_LIM_RELEASE;
            s_reg.det_sel <= `TXDYN_RST_QUALITY_SELECT;
            s_reg.quiet_input_threshold <= `TXDYN_RST_QUIET_THRESHOLD;
            s_reg.quiet_input_duration <= `TXDYN_RST_QUIET_DURATION;
            s_reg.cts <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // every output straight from the state register
    assign o_cts = s_reg.cts;
    assign o_rvalid = s_reg.rvalid;
    assign o_rdata = s_reg.rdata;
    assign o_err = s_reg.err;
    assign o_stat_valid = s_reg.stat_valid;
    assign o_stat = s_reg.stat;
    assign o_gain_db = s_reg.gain_out;
    assign o_comp_releasing = s_reg.rel_active;
    assign o_lim_release_start = s_reg.lim_start;
    assign o_limiter_release_count = s_reg.limiter_release_count;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_access;
        i_cmd.valid && o_cts;
    endsequence
    sequence s_busy_then_ready;
        !o_cts ##1 o_cts;
    endsequence

    property p_release_code;
        s_reg.comp_rel <= `TXDYN_COMP_RELEASE_MAX;
    endproperty
    a_release_code: assert property (p_release_code)
        else $error("release code out of range");

    property p_release_load;
        (s_reg.above_comp && !comp_above) |=>
            s_reg.rel_left == txdyn_release_ms($past(s_reg.comp_rel)) && o_comp_releasing;
    endproperty
    a_release_load: assert property (p_release_load)
        else $error("release time not loaded on fall");

    property p_gain_range;
        s_reg.comp_gain <= `TXDYN_COMP_GAIN_MAX;
    endproperty
    a_gain_range: assert property (p_gain_range)
        else $error("gain above 20 dB");

    property p_gain_below;
        !comp_above |=> o_gain_db == $past(s_reg.comp_gain);
    endproperty
    a_gain_below: assert property (p_gain_below)
        else $error("gain not applied below threshold");

    property p_cts_cycle;
        s_access |=> s_busy_then_ready;
    endproperty
    a_cts_cycle: assert property (p_cts_cycle)
        else $error("clear-to-send did not cycle");

    property p_lim_range;
        s_reg.limiter_release_count >= `TXDYN_LIM_RELEASE_MIN &&
        s_reg.limiter_release_count <= `TXDYN_LIM_RELEASE_MAX;
    endproperty
    a_lim_range: assert property (p_lim_range)
        else $error("limiter release out of range");

    property p_lim_start;
        ($past(i_over_limit) && !i_over_limit) |=> o_lim_release_start;
    endproperty
    a_lim_start: assert property (p_lim_start)
        else $error("limiter release not started");

    property p_status_mask;
        o_stat_valid |-> ({o_stat.overdeviation_flag, o_stat.loud_input_flag,
                           o_stat.quiet_input_flag} & ~s_reg.det_sel) == 3'h0;
    endproperty
    a_status_mask: assert property (p_status_mask)
        else $error("disabled flag reported");

    property p_untuned_quiet;
        !s_reg.tuned |-> s_reg.flags == 3'h0;
    endproperty
    a_untuned_quiet: assert property (p_untuned_quiet)
        else $error("flag set before tune");

    property p_reserved_zero;
        (s_access and (i_cmd.prop == `TXDYN_PROP_COMP_RELEASE && !i_cmd.write &&
         i_powered_up)) |=> o_rdata[15:3] == 13'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");

    // an access taken while powered down answers with err and no data
    property p_unpowered_refused;
        (s_access and (!i_powered_up)) |=> o_err && !o_rvalid;
    endproperty
    a_unpowered_refused: assert property (p_unpowered_refused)
        else $error("access served while powered down");

    // an out-of-range release code is refused and the old code kept
    property p_release_refused;
        (s_access and (i_cmd.write && i_powered_up &&
         i_cmd.prop == `TXDYN_PROP_COMP_RELEASE &&
         i_cmd.data > 16'(`TXDYN_COMP_RELEASE_MAX))) |=> o_err && $stable(s_reg.comp_rel);
    endproperty
    a_release_refused: assert property (p_release_refused)
        else $error("bad release code accepted");

    // a quiet hit always lands in the flags, even against a status clear
    property p_quiet_sets_flag;
        quiet_hit |=> s_reg.flags[`TXDYN_SEL_QUIET_BIT];
    endproperty
    a_quiet_sets_flag: assert property (p_quiet_sets_flag)
        else $error("quiet hit lost");
endmodule

/* verification/txdyn_host_model.sv */
/*
 * Host controller model for the property port: one access at a time.
 * Assumes it shares i_clk with the block and drives on falling edges.
 */
`timescale 1ns/1ns
module txdyn_host_model (
    input  wire logic               i_clk,
    input  wire logic               i_pwr,
    input  wire logic               i_cts,
    input  wire logic               i_err,
    input  wire logic [15:0]        i_rdata,
    output txdyn_pkg::txdyn_cmd_t   o_cmd
);
    import txdyn_pkg::*;
    initial o_cmd = '0;
    // wait for clear-to-send and power, hold the request over the taking edge;
    // gives up waiting after 50 cycles so a refused access can be provoked
    task automatic acc(input logic w, input logic [15:0] p, input logic [15:0] d,
                       output logic [15:0] rd, output logic er);
        int n;
        n = 0;
        @(negedge i_clk);
        while (!(i_cts === 1'b1 && i_pwr === 1'b1) && n < 50) begin
            @(negedge i_clk);
            n++;
        end
        o_cmd = '{valid: 1'b1, write: w, prop: p, data: d};
        @(negedge i_clk);
        // released data is not held: show its inverse so stale values are not trusted
        o_cmd = '{valid: 1'b0, write: ~w, prop: ~p, data: ~d};
        rd = i_rdata;
        er = i_err;
    endtask
endmodule

/* verification/txdyn_top_tb.sv */
/*
 * Self-checking bench for txdyn_top: settings, dynamics and quality status.
 * Assumes txdyn_pkg is compiled first; ms unit shortened to 4 cycles.
 */
`timescale 1ns/1ns
module txdyn_top_tb;
    import txdyn_pkg::*;
    localparam int MS = 4;
    logic i_clk = 0, i_srst = 1, i_tune_cmd = 0, i_status_req = 0;
    logic i_over_limit = 0, i_overdev_event = 0, i_loud_event = 0, i_powered_up = 1;
    logic [7:0] i_level_dbfs = 8'h00;
    logic o_cts, o_rvalid, o_err, o_stat_valid, o_comp_releasing, o_lim_release_start;
    logic [15:0] o_rdata, o_limiter_release_count;
    logic [5:0] o_gain_db;
    txdyn_status_t o_stat;
    txdyn_cmd_t cmd;
    int bad_count = 0, n_tests = 0;
    // 25 MHz clock
    always #20 i_clk = ~i_clk;
    txdyn_top #(.MS_CYCLES(MS)) dut (.i_clk(i_clk), .i_srst(i_srst), .i_powered_up(i_powered_up),
        .i_cmd(cmd), .i_tune_cmd(i_tune_cmd), .i_status_req(i_status_req),
        .i_level_dbfs(i_level_dbfs), .i_over_limit(i_over_limit),
        .i_overdev_event(i_overdev_event), .i_loud_event(i_loud_event), .o_cts(o_cts),
        .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_err(o_err), .o_stat_valid(o_stat_valid),
        .o_stat(o_stat), .o_gain_db(o_gain_db), .o_comp_releasing(o_comp_releasing),
        .o_lim_release_start(o_lim_release_start),
        .o_limiter_release_count(o_limiter_release_count));
    txdyn_host_model host (.i_clk(i_clk), .i_pwr(i_powered_up), .i_cts(o_cts), .i_err(o_err),
        .i_rdata(o_rdata), .o_cmd(cmd));
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rdc(input logic [15:0] p, input logic [15:0] e);
        logic [15:0] v;
        logic r;
        host.acc(1'b0, p, 16'h0000, v, r);
        chk("rdata", v, e);
        chk("rvalid", {15'h0000, o_rvalid}, 16'h0001);
    endtask
    task automatic wrc(input logic [15:0] p, input logic [15:0] d, input logic e);
        logic [15:0] v;
        logic r;
        host.acc(1'b1, p, d, v, r);
        chk("err", {15'h0000, r}, {15'h0000, e});
    endtask
    task automatic stq(input logic [3:0] e);
        @(negedge i_clk) i_status_req = 1;
        @(negedge i_clk) i_status_req = 0;
        chk("stval", {15'h0000, o_stat_valid}, 16'h0001);
        chk("stat", {12'h000, o_stat}, {12'h000, e});
    endtask
    task automatic pulse(ref logic s);
        @(negedge i_clk) s = 1;
        @(negedge i_clk) s = 0;
    endtask
    task automatic t_reset();
        rdc(16'h2203, 16'h0004);
        rdc(16'h2204, 16'h000F);
        rdc(16'h2205, 16'h0066);
        rdc(16'h2300, 16'h0000);
        rdc(16'h2301, 16'h0000);
        rdc(16'h2302, 16'h0000);
        rdc(16'h2201, 16'hFFD8);
        chk("busy", {15'h0000, o_cts}, 16'h0000);
        @(negedge i_clk);
        chk("cts", {15'h0000, o_cts}, 16'h0001);
    endtask
    task automatic t_ranges();
        wrc(16'h2203, 16'h0005, 1'b1);
        rdc(16'h2203, 16'h0004);
        wrc(16'h2204, 16'h0015, 1'b1);
        wrc(16'h2204, 16'h0014, 1'b0);
        i_powered_up = 0;
        wrc(16'h2204, 16'h0003, 1'b1);
        i_powered_up = 1;
        rdc(16'h2204, 16'h0014);
        wrc(16'h2205, 16'h0004, 1'b1);
        wrc(16'h2205, 16'h07D0, 1'b0);
        chk("lim", o_limiter_release_count, 16'h07D0);
        wrc(16'h2301, 16'h00BA, 1'b0);
        rdc(16'h2301, 16'h00BA);
    endtask
    // gain below threshold, none above, then a release window of 100 ms
    task automatic t_comp();
        wrc(16'h2204, 16'h0007, 1'b0);
        wrc(16'h2203, 16'h0000, 1'b0);
        i_level_dbfs = 8'hCE;
        repeat (3) @(negedge i_clk);
        chk("gain", {10'h000, o_gain_db}, 16'h0007);
        i_level_dbfs = 8'hF6;
        repeat (3) @(negedge i_clk);
        chk("gain", {10'h000, o_gain_db}, 16'h0000);
        i_level_dbfs = 8'hCE;
        repeat (3) @(negedge i_clk);
        chk("rel", {15'h0000, o_comp_releasing}, 16'h0001);
        repeat (90 * MS) @(negedge i_clk);
        chk("rel", {15'h0000, o_comp_releasing}, 16'h0001);
        repeat (20 * MS) @(negedge i_clk);
        chk("rel", {15'h0000, o_comp_releasing}, 16'h0000);
    endtask
    task automatic t_lim();
        int n;
        n = 0;
        pulse(i_over_limit);
        repeat (4) @(negedge i_clk) n += o_lim_release_start;
        chk("limstart", n[15:0], 16'h0001);
    endtask
    // detectors: nothing before tune, then only enabled flags, quiet after full duration
    task automatic t_quality();
        i_level_dbfs = 8'h00;
        wrc(16'h2300, 16'h0007, 1'b0);
        stq(4'h0);
        wrc(16'h2300, 16'h0004, 1'b0);
        pulse(i_overdev_event);
        pulse(i_tune_cmd);
        stq(4'h8);
        pulse(i_overdev_event);
        pulse(i_loud_event);
        stq(4'hC);
        wrc(16'h2300, 16'h0001, 1'b0);
        wrc(16'h2301, 16'h00EC, 1'b0);
        wrc(16'h2302, 16'h0003, 1'b0);
        stq(4'h8);
        i_level_dbfs = 8'hCE;
        pulse(i_loud_event);
        stq(4'h8);
        repeat (6 * MS) @(negedge i_clk);
        stq(4'h9);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence after a 20-cycle reset
    initial begin
        repeat (20) @(negedge i_clk);
        i_srst = 0;
        t_reset();
        t_ranges();
        t_comp();
        t_lim();
        t_quality();
        final_report();
    end
    // watchdog: the run needs well under 3000 cycles
    initial begin
        #400000;
        bad_count++;
        final_report();
    end
endmodule
